// ==== include/cpu_ctrl_defs.svh ====
// offsets, field positions, reset values and counts for the core control registers
`ifndef CPU_CTRL_DEFS_SVH
`define CPU_CTRL_DEFS_SVH

// printed offsets are not all multiples of four: these are indices, byte address = 4 * index
`define GUARD_IDX        6'h04
`define STACK_LOW_IDX    6'h0D
`define STACK_HIGH_IDX   6'h0E
`define FLAGS_IDX        6'h0F
`define CORE_EVENT_IDX   6'h10
`define WINDOW_STAT_IDX  6'h11

`define KEY_SELF_PROG    8'h9D
`define KEY_IO_UNLOCK    8'hD8

`define GUARD_RESET      8'h00
`define FLAGS_RESET      8'h00

`define FLAG_IE          7
`define FLAG_TBIT        6
`define FLAG_HALF        5
`define FLAG_SIGN        4
`define FLAG_OVF         3
`define FLAG_NEG         2
`define FLAG_ZERO        1
`define FLAG_CARRY       0

`define GUARD_IO_BIT     0
`define GUARD_SPM_BIT    1

`define WINDOW_INSNS     3'd4
`define STACK_BITS       12
`define STACK_TOP        12'hFFF

`endif

// ==== include/cpu_ctrl_pkg.sv ====
// types for the core control registers
package cpu_ctrl_pkg;
    typedef enum logic [1:0] {
        guard_closed,
        guard_io_open,
        guard_spm_open
    } guard_state_e;

    typedef enum logic [1:0] {
        bus_idle,
        bus_wait,
        bus_done
    } bus_state_e;
endpackage

// ==== core/cpu_control_registers.sv ====
// core control registers: change guard, stack pointer and flag register on avalon-mm
`include "cpu_ctrl_defs.svh"

// Notes on behaviour
// R1 - guard accepts 0x9D for self-programming and 0xD8 for I/O unlock; others ignored
// R2 - a valid key opens a window lasting the next four executed instructions
// R3 - no interrupt serviced while the guard window is open; pending ones follow
// R4 - guard bit 0 reads one while the I/O unlock window is open
// R5 - guard bit 1 reads one while the self-programming window is open
// R6 - guard bits 7 to 2 always read zero
// R7 - reset loads the stack pointer with the top of internal RAM
// R8 - stack pointer keeps only implemented bits; the rest read zero
// R9 - stack low byte at base offset, high byte at base plus one
// R10 - low byte write masks interrupts four instructions or until next I/O write
// R11 - flag bit 7 is global interrupt enable; zero blocks every interrupt
// R12 - taking an interrupt never clears the global interrupt enable
// R13 - irq_on_op sets and irq_off_op clears the global interrupt enable
// R14 - a bus write changing the enable bit costs one extra wait cycle
// R15 - flag bit 6 is the transfer bit for bit_save_op and bit_restore_op
// R16 - flag bit 4 always equals negative xor overflow
// R17 - half carry 5, overflow 3, negative 2, zero 1, carry 0
// R18 - software writes low byte first; it waits in a temporary until the high byte
// R19 - requests during the guard window stay pending until it ends
// R20 - one protected access closes the window; another needs the key again
module cpu_control_registers
    import cpu_ctrl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        insn_retired,
    input  wire logic        protected_access,
    input  wire logic        io_mem_write,
    input  wire logic        irq_on_op,
    input  wire logic        irq_off_op,
    input  wire logic        bit_save_op,
    input  wire logic        bit_save_value,
    input  wire logic        alu_flags_valid,
    input  wire logic [4:0]  alu_flags,
    input  wire logic        irq_pending,
    output logic             irq_allowed,
    output logic             io_unlock_key,
    output logic             self_program_key,
    output logic             bit_restore_op,
    output logic [15:0]      stack_top_pointer
);

    // control state
    guard_state_e             guard_state;
    guard_state_e             next_guard_state;
    bus_state_e               bus_state;
    bus_state_e               next_bus_state;
    logic [2:0]               guard_left;
    logic [2:0]               next_guard_left;
    logic [2:0]               sp_mask_left;
    logic [2:0]               next_sp_mask_left;
    logic [7:0]               stack_low_byte;
    logic [7:0]               flags;
    logic [7:0]               next_flags;
    logic [7:0]               event_count;
    logic [7:0]               next_event_count;

    // bus decode
    logic [5:0]               word_idx;
    logic                     access;
    logic                     write_ok;
    logic                     guard_wr;
    logic                     low_wr;
    logic                     high_wr;
    logic                     flags_wr;
    logic [7:0]               wr_byte;
    logic                     ie_change;
    logic                     next_waitrequest;
    logic [7:0]               guard_read;
    logic [31:0]              read_word;

    // interrupt gate terms
    logic                     guard_quiet;
    logic                     stack_quiet;
    logic                     next_irq_allowed;

    function automatic logic [7:0] with_sign(input logic [7:0] f);
        logic [7:0] r;
        r = f;
        r[`FLAG_SIGN] = f[`FLAG_NEG] ^ f[`FLAG_OVF]; // R16
        return r;
    endfunction

    // byte lane 0 carries every register here, so the index alone selects
    function automatic logic idx_hit(input logic [5:0] idx, input logic [5:0] target);
        return idx == target;
    endfunction

    function automatic logic [31:0] byte_word(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    // any value other than the two keys maps to closed and opens nothing
    function automatic guard_state_e key_window(input logic [7:0] b);
        guard_state_e s;
        s = guard_closed;
        if (b == `KEY_IO_UNLOCK) begin
            s = guard_io_open; // R1
        end else if (b == `KEY_SELF_PROG) begin
            s = guard_spm_open; // R1
        end
        return s;
    endfunction

    // shared by both instruction windows; saturates at zero
    function automatic logic [2:0] tick_down(input logic [2:0] cnt, input logic step);
        logic [2:0] r;
        r = cnt;
        if (step && cnt != 3'd0) begin
            r = cnt - 3'd1;
        end
        return r;
    endfunction

    function automatic logic [7:0] apply_alu(input logic [7:0] f, input logic [4:0] a);
        logic [7:0] r;
        r = f;
        r[`FLAG_HALF]  = a[4]; // R17
        r[`FLAG_OVF]   = a[3];
        r[`FLAG_NEG]   = a[2];
        r[`FLAG_ZERO]  = a[1];
        r[`FLAG_CARRY] = a[0];
        return r;
    endfunction

    assign word_idx  = avs_address[7:2];
    assign access    = avs_read | avs_write;
    assign wr_byte   = avs_writedata[7:0];
    // register effects happen at the edge where waitrequest is sampled low
    assign write_ok  = avs_write & avs_byteenable[0] & (bus_state == bus_done);
    assign guard_wr  = write_ok & idx_hit(word_idx, `GUARD_IDX);
    assign low_wr    = write_ok & idx_hit(word_idx, `STACK_LOW_IDX);  // R9
    assign high_wr   = write_ok & idx_hit(word_idx, `STACK_HIGH_IDX); // R9
    assign flags_wr  = write_ok & idx_hit(word_idx, `FLAGS_IDX);
    assign ie_change = avs_write & avs_byteenable[0] & idx_hit(word_idx, `FLAGS_IDX)
                     & (wr_byte[`FLAG_IE] != flags[`FLAG_IE]);

    // bus handshake: one wait cycle normally, two when the enable bit changes
    always_comb begin
        next_bus_state = bus_state;
        unique case (bus_state)
            bus_idle: begin
                if (access) begin
                    next_bus_state = ie_change ? bus_wait : bus_done; // R14
                end
            end
            bus_wait: begin
                next_bus_state = bus_done;
            end
            bus_done: begin
                next_bus_state = bus_idle;
            end
            default: begin
                next_bus_state = bus_idle;
            end
        endcase
    end

    always_comb begin
        next_waitrequest = 1'b1;
        if (access && bus_state == bus_idle && !ie_change) begin
            next_waitrequest = 1'b0;
        end
        if (access && bus_state == bus_wait) begin
            next_waitrequest = 1'b0; // R14
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_state       <= bus_idle;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_state       <= next_bus_state;
            avs_waitrequest <= next_waitrequest;
        end
    end

    always_comb begin
        guard_read = 8'h00; // R6
        guard_read[`GUARD_IO_BIT]  = (guard_state == guard_io_open);  // R4
        guard_read[`GUARD_SPM_BIT] = (guard_state == guard_spm_open); // R5
    end

    // unmapped indices read zero rather than aliasing a neighbour
    always_comb begin
        unique case (word_idx)
            `GUARD_IDX:       read_word = byte_word(guard_read);
            `STACK_LOW_IDX:   read_word = byte_word(stack_top_pointer[7:0]);
            `STACK_HIGH_IDX:  read_word = byte_word(stack_top_pointer[15:8]);
            `FLAGS_IDX:       read_word = byte_word(flags);
            `CORE_EVENT_IDX:  read_word = byte_word(event_count);
            `WINDOW_STAT_IDX: read_word = {29'h0000000, sp_mask_left};
            default:          read_word = 32'h0000_0000;
        endcase
    end

    // captured while the request waits, so it already stands when waitrequest drops
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && bus_state != bus_done) begin
            avs_readdata <= read_word;
        end
    end

    // guard window: counts retired instructions; a protected access ends it early
    always_comb begin
        next_guard_state = guard_state;
        next_guard_left  = guard_left;
        if (guard_wr && key_window(wr_byte) != guard_closed) begin // R1
            next_guard_state = key_window(wr_byte);
            next_guard_left  = `WINDOW_INSNS; // R2
        end else if (guard_state != guard_closed) begin
            if (protected_access || (insn_retired && guard_left == 3'd1)) begin
                next_guard_state = guard_closed; // R20 R2
                next_guard_left  = 3'd0;
            end else begin
                next_guard_left = tick_down(guard_left, insn_retired); // R2
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            guard_state <= guard_closed;
            guard_left  <= 3'd0;
        end else begin
            guard_state <= next_guard_state;
            guard_left  <= next_guard_left;
        end
    end

    // low byte write masks interrupts; a later I/O write cuts it short
    always_comb begin
        next_sp_mask_left = tick_down(sp_mask_left, insn_retired); // R10
        if (io_mem_write) begin
            next_sp_mask_left = 3'd0; // R10
        end
        if (low_wr) begin
            next_sp_mask_left = `WINDOW_INSNS; // R10
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sp_mask_left <= 3'd0;
        end else begin
            sp_mask_left <= next_sp_mask_left;
        end
    end

    // low byte waits in a temporary so both halves land together
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stack_low_byte <= 8'h00;
        end else if (low_wr) begin
            stack_low_byte <= wr_byte; // R18
        end
    end

    // unimplemented upper bits are never stored, so they cannot read back as one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stack_top_pointer <= {{(16-`STACK_BITS){1'b0}}, `STACK_TOP}; // R7
        end else if (high_wr) begin
            stack_top_pointer <= {{(16-`STACK_BITS){1'b0}}, wr_byte[`STACK_BITS-9:0], stack_low_byte}; // R8 R18
        end
    end

    // flags: bus write, then core events; sign recomputed from the result
    always_comb begin
        next_flags = flags;
        if (flags_wr) begin
            next_flags = wr_byte;
        end
        if (alu_flags_valid) begin
            next_flags = apply_alu(next_flags, alu_flags); // R17
        end
        if (bit_save_op) begin
            next_flags[`FLAG_TBIT] = bit_save_value; // R15
        end
        if (irq_on_op) begin
            next_flags[`FLAG_IE] = 1'b1; // R13
        end else if (irq_off_op) begin
            next_flags[`FLAG_IE] = 1'b0; // R13
        end
        next_flags = with_sign(next_flags); // R16
    end

    // enable bit is only changed above; interrupt entry never touches it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags <= `FLAGS_RESET;
        end else begin
            flags <= next_flags; // R12
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bit_restore_op <= 1'b0;
        end else begin
            bit_restore_op <= next_flags[`FLAG_TBIT]; // R15
        end
    end

    // pending requests simply wait in the interrupt controller until the gate reopens
    assign guard_quiet = (guard_state == guard_closed); // R3 R19
    // the write edge itself is masked too, before the counter has loaded
    assign stack_quiet = (sp_mask_left == 3'd0) & !low_wr; // R10
    assign next_irq_allowed = next_flags[`FLAG_IE] & guard_quiet & stack_quiet; // R11

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_allowed <= 1'b0;
        end else begin
            irq_allowed <= next_irq_allowed;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            io_unlock_key    <= 1'b0;
            self_program_key <= 1'b0;
        end else begin
            io_unlock_key    <= (guard_state == guard_io_open);  // R4
            self_program_key <= (guard_state == guard_spm_open); // R5
        end
    end

    // counts cycles in which a request waited behind the guard window, saturating
    always_comb begin
        next_event_count = event_count;
        if (irq_pending && !guard_quiet && event_count != 8'hFF) begin
            next_event_count = event_count + 8'h01; // R19
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            event_count <= 8'h00;
        end else begin
            event_count <= next_event_count;
        end
    end

endmodule

// ==== dv/cpu_control_registers_properties.sv ====
// port-level assertions for the core control registers
module cpu_control_registers_properties (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        insn_retired,
    input wire logic        protected_access,
    input wire logic        irq_on_op,
    input wire logic        irq_off_op,
    input wire logic        bit_save_op,
    input wire logic        bit_save_value,
    input wire logic        irq_allowed,
    input wire logic        io_unlock_key,
    input wire logic        self_program_key,
    input wire logic        bit_restore_op,
    input wire logic [15:0] stack_top_pointer
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // counts instructions seen while a window is open; a late close shows as a count of four
    logic [2:0] insn_cnt;
    wire        win = io_unlock_key | self_program_key;
    always_ff @(posedge sys_clk) begin
        insn_cnt <= (rst || !win) ? 3'h0 : insn_cnt + {2'h0, insn_retired};
    end
    sequence done_wr(a);
        avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == a;
    endsequence
    a_io_key_opens: assert property ((done_wr(8'h10) ##0 avs_writedata[7:0] == 8'hD8) |-> ##2 io_unlock_key)
        else $error("io key did not open");
    a_spm_key_opens: assert property ((done_wr(8'h10) ##0 avs_writedata[7:0] == 8'h9D) |-> ##2 self_program_key)
        else $error("spm key did not open");
    a_window_four_insns: assert property (insn_cnt == 3'h4 |=> !win)
        else $error("window outlived four instructions");
    a_window_mutes_irq: assert property (win |-> !irq_allowed)
        else $error("irq allowed in window");
    a_single_access: assert property (protected_access && win |-> ##2 !win)
        else $error("window open after protected access");
    a_stack_mask: assert property (done_wr(8'h34) |=> !irq_allowed)
        else $error("irq allowed after stack low write");
    a_irq_off_blocks: assert property (irq_off_op && !irq_on_op |-> ##[1:2] !irq_allowed)
        else $error("irq still allowed after off op");
    a_tbit_copy: assert property (bit_save_op |=> bit_restore_op == $past(bit_save_value))
        else $error("transfer bit not loaded");
    a_stack_upper_zero: assert property (stack_top_pointer[15:12] == 4'h0)
        else $error("unimplemented stack bits set");
    a_answer_bounded: assert property ($rose(avs_read || avs_write) |-> ##[1:2] !avs_waitrequest)
        else $error("bus answer late");
endmodule

bind cpu_control_registers cpu_control_registers_properties u_props (
    .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_waitrequest, .insn_retired, .protected_access, .irq_on_op, .irq_off_op, .bit_save_op,
    .bit_save_value, .irq_allowed, .io_unlock_key, .self_program_key, .bit_restore_op, .stack_top_pointer
);

// ==== dv/tb_cpu_control_registers.sv ====
// self-checking bench for the core control registers
module tb_cpu_control_registers;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [6:0]  ops = 7'h00;
    logic        bit_save_value = 1'b1;
    logic [4:0]  alu_flags = 5'h00;
    logic        irq_pending = 1'b1;
    logic        irq_allowed, io_unlock_key, self_program_key, bit_restore_op;
    logic [15:0] stack_top_pointer;
    logic [31:0] exp_q[$];
    int          error_cnt = 0;
    int          check_count = 0;
    int          seed = 32;
    int          nw;
    logic [7:0]  lo, hi, v;
    always #2.5 sys_clk = ~sys_clk;
    cpu_control_registers u_dut (
        .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
        .avs_readdata, .avs_waitrequest, .insn_retired(ops[0]), .protected_access(ops[1]),
        .io_mem_write(ops[2]), .irq_on_op(ops[3]), .irq_off_op(ops[4]), .bit_save_op(ops[5]),
        .bit_save_value, .alu_flags_valid(ops[6]), .alu_flags, .irq_pending, .irq_allowed,
        .io_unlock_key, .self_program_key, .bit_restore_op, .stack_top_pointer
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // reads note the expected word; the monitor below compares it at the answering edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        nw = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= {24'h0, d};
        if (!w) exp_q.push_back({24'h0, d});
        do begin
            @(posedge sys_clk);
            nw++;
        end while (avs_waitrequest && nw < 50);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic pulse(input logic [6:0] p);
        @(posedge sys_clk);
        ops <= p;
        @(posedge sys_clk);
        ops <= 7'h00;
    endtask
    // two cycles of slack: the interrupt gate may lag its cause by a register stage
    task automatic settle;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (avs_read && !avs_waitrequest) chk(avs_readdata, exp_q.pop_front());
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        bus(0, 8'h10, 8'h00);
        bus(0, 8'h34, 8'hFF);
        bus(0, 8'h38, 8'h0F);
        bus(0, 8'h3C, 8'h00);
        bus(0, 8'h80, 8'h00);
        chk(irq_allowed, 0);
        $display("test reset done");
        bus(1, 8'h3C, 8'h80);
        chk(nw, 3);
        settle();
        chk(irq_allowed, 1);
        pulse(7'h10);
        settle();
        chk(irq_allowed, 0);
        pulse(7'h08);
        settle();
        chk(irq_allowed, 1);
        $display("test enable done");
        for (int k = 0; k < 2; k++) begin
            bus(1, 8'h10, k ? 8'h9D : 8'hD8);
            settle();
            chk({io_unlock_key, self_program_key}, k ? 2'b01 : 2'b10);
            chk(irq_allowed, 0);
            bus(0, 8'h10, k ? 8'h02 : 8'h01);
            if (k) pulse(7'h02);
            else begin
                repeat (3) pulse(7'h01);
                settle();
                chk(io_unlock_key, 1);
                pulse(7'h01);
            end
            settle();
            chk({io_unlock_key, self_program_key}, 2'b00);
            chk(irq_allowed, 1);
        end
        v = 8'($random(seed)) | 8'h02;
        bus(1, 8'h10, v);
        settle();
        chk({io_unlock_key, self_program_key}, 2'b00);
        bus(0, 8'h10, 8'h00);
        $display("test guard done");
        lo = 8'($random(seed));
        hi = 8'($random(seed));
        bus(1, 8'h34, lo);
        settle();
        chk(irq_allowed, 0);
        pulse(7'h04);
        settle();
        chk(irq_allowed, 1);
        bus(1, 8'h38, hi);
        bus(0, 8'h34, lo);
        bus(0, 8'h38, {4'h0, hi[3:0]});
        chk(stack_top_pointer, {20'h0, hi[3:0], lo});
        $display("test stack done");
        alu_flags <= 5'b01000;
        pulse(7'h40);
        bus(0, 8'h3C, 8'h98);
        alu_flags <= 5'b10111;
        pulse(7'h40);
        bus(0, 8'h3C, 8'hB7);
        pulse(7'h20);
        settle();
        chk(bit_restore_op, 1);
        bus(0, 8'h3C, 8'hF7);
        $display("test flags done");
        print_verdict();
    end
endmodule
